// ===== verilog/dacrp_pkg.sv
`default_nettype none
package dacrp_pkg;
	localparam int unsigned DACRP_DATA_W = 14;
	localparam int unsigned DACRP_MSB = 13;
	// conversion timing at a 125 MHz clock
	localparam int unsigned DACRP_CLK_PERIOD_PS = 8000;
	localparam int unsigned DACRP_CONV_TIME_NS = 5200;
	localparam int unsigned DACRP_SLEEP_CONV_TIME_NS = 10000;
	localparam int unsigned DACRP_CONV_CYCLES = (DACRP_CONV_TIME_NS * 1000) / DACRP_CLK_PERIOD_PS;
	localparam int unsigned DACRP_SLEEP_CONV_CYCLES = (DACRP_SLEEP_CONV_TIME_NS * 1000) / DACRP_CLK_PERIOD_PS;
	localparam int unsigned DACRP_CNT_W = 11;
	// result coding selector
	localparam logic DACRP_CODE_TWOS = 1'h0;
	localparam logic DACRP_CODE_BINARY = 1'h1;
	typedef enum logic [1:0]
	{
		DACRP_IDLE = 2'b00,
		DACRP_CONVERT = 2'b01,
		DACRP_DONE = 2'b10
	} dacrp_state_e;
endpackage : dacrp_pkg
`default_nettype wire

// ===== verilog/dacrp_result_mem.sv
`timescale 1ns/1ns
`default_nettype none
// two result words per conversion; read data come from a register
module dacrp_result_mem #(
	parameter int unsigned WIDTH = 14
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic rstn_in,
	// write side
	input wire logic wr_en_in,
	input wire logic [WIDTH-1:0] wr_data1_in,
	input wire logic [WIDTH-1:0] wr_data2_in,
	// read side
	input wire logic rd_sel_in,
	output logic [WIDTH-1:0] rd_data_out
);
	logic [WIDTH-1:0] word_reg [2];
	logic [WIDTH-1:0] word_next [2];
	logic [WIDTH-1:0] rd_data_reg;
	logic [WIDTH-1:0] rd_data_next;

	always_comb
	begin
		word_next[0] = wr_en_in ? wr_data1_in : word_reg[0];
		word_next[1] = wr_en_in ? wr_data2_in : word_reg[1];
		rd_data_next = word_reg[rd_sel_in];
	end

	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			word_reg[0] <= '0;
			word_reg[1] <= '0;
			rd_data_reg <= '0;
		end
		else
		begin
			word_reg[0] <= word_next[0];
			word_reg[1] <= word_next[1];
			rd_data_reg <= rd_data_next;
		end
	end

	assign rd_data_out = rd_data_reg;
endmodule : dacrp_result_mem
`default_nettype wire

// ===== verilog/dacrp_top.sv
// Summary of operation
// - start edge holds and converts both inputs
// - busy high from start edge to end
// - select low converts channel A pair
// - select high converts channel B pair
// - read port responds only while chip select low; start edges convert regardless
// - drive data only while read and select low
// - 14-bit result, bit 13 MSB, three-state
// - twos complement bipolar, binary unipolar
// - first read input 1, second input 2
// - busy lasts 5.2 us, sleep 10 us
`timescale 1ns/1ns
`default_nettype none
module dacrp_top
#(
	parameter int unsigned DATA_W = dacrp_pkg::DACRP_DATA_W,
	parameter logic CODING = dacrp_pkg::DACRP_CODE_TWOS
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic rstn_in,
	// conversion control
	input wire logic convert_start_n_in,
	input wire logic pair_select_in,
	input wire logic auto_sleep_in,
	output logic busy_out,
	// digitised samples from the converter cores (offset binary)
	input wire logic [DATA_W-1:0] chan_a_input1_in,
	input wire logic [DATA_W-1:0] chan_a_input2_in,
	input wire logic [DATA_W-1:0] chan_b_input1_in,
	input wire logic [DATA_W-1:0] chan_b_input2_in,
	// parallel read port
	input wire logic chip_select_n_in,
	input wire logic read_n_in,
	output logic [DATA_W-1:0] result_bus_out,
	output logic result_bus_oe_out,
	output logic hold_out
);
	import dacrp_pkg::*;

	////////////////////////////////////////////////////////////////////////
	dacrp_state_e state_reg, state_next;
	logic [DACRP_CNT_W-1:0] cnt_reg, cnt_next;
	logic [DACRP_CNT_W-1:0] busy_span_reg, busy_span_next;
	logic conv_prev_reg, conv_prev_next;
	logic sel_reg, sel_next;
	logic sleep_reg, sleep_next;
	logic [DATA_W-1:0] hold1_reg, hold1_next, hold2_reg, hold2_next;
	logic rd_ptr_reg, rd_ptr_next;
	logic rd_prev_reg, rd_prev_next;
	logic start_edge;
	logic read_active;
	logic conv_end;
	logic [DATA_W-1:0] mem_data;

	function automatic logic [DATA_W-1:0] code_result(input logic [DATA_W-1:0] raw);
		// cores deliver offset binary; bipolar variants flip the msb
		code_result = (CODING == DACRP_CODE_TWOS) ? {~raw[DATA_W-1], raw[DATA_W-2:0]} : raw;
	endfunction : code_result

	assign start_edge = conv_prev_reg && !convert_start_n_in;
	assign read_active = !chip_select_n_in && !read_n_in;
	assign conv_end = (state_reg == DACRP_CONVERT) && (cnt_reg == '0);

	////////////////////////////////////////////////////////////////////////
	// conversion sequencer
	always_comb
	begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		sel_next = sel_reg;
		sleep_next = sleep_reg;
		hold1_next = hold1_reg;
		hold2_next = hold2_reg;
		conv_prev_next = convert_start_n_in;
		unique case (state_reg)
			DACRP_IDLE, DACRP_DONE:
			begin
				if (start_edge)
				begin
					state_next = DACRP_CONVERT;
					sel_next = pair_select_in;
					sleep_next = auto_sleep_in;
					// both inputs of the chosen pair are frozen in the same cycle
					hold1_next = pair_select_in ? chan_b_input1_in : chan_a_input1_in;
					hold2_next = pair_select_in ? chan_b_input2_in : chan_a_input2_in;
					cnt_next = auto_sleep_in ? DACRP_CNT_W'(DACRP_SLEEP_CONV_CYCLES - 1)
						: DACRP_CNT_W'(DACRP_CONV_CYCLES - 1);
				end
			end
			DACRP_CONVERT:
			begin
				// further start edges while busy are ignored
				if (conv_end)
					state_next = DACRP_DONE;
				else
					cnt_next = cnt_reg - DACRP_CNT_W'(1);
			end
			default:
				state_next = DACRP_IDLE;
		endcase
	end

	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			state_reg <= DACRP_IDLE;
			cnt_reg <= '0;
			conv_prev_reg <= 1'h1;
			sel_reg <= 1'h0;
			sleep_reg <= 1'h0;
			hold1_reg <= '0;
			hold2_reg <= '0;
		end
		else
		begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			conv_prev_reg <= conv_prev_next;
			sel_reg <= sel_next;
			sleep_reg <= sleep_next;
			hold1_reg <= hold1_next;
			hold2_reg <= hold2_next;
		end
	end

	assign busy_out = (state_reg == DACRP_CONVERT);
	assign hold_out = (state_reg == DACRP_CONVERT);

	////////////////////////////////////////////////////////////////////////
	// counts busy cycles so the long sleep window is checked without a wide delay range
	always_comb
	begin
		busy_span_next = busy_out ? busy_span_reg + DACRP_CNT_W'(1) : '0;
	end

	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
			busy_span_reg <= '0;
		else
			busy_span_reg <= busy_span_next;
	end

	////////////////////////////////////////////////////////////////////////
	// read sequencing: pointer goes to word 2 at the end of a read strobe and stays there until a start edge outside a conversion
	always_comb
	begin
		rd_prev_next = read_active;
		rd_ptr_next = rd_ptr_reg;
		if (start_edge && state_reg != DACRP_CONVERT)
			rd_ptr_next = 1'h0;
		else if (rd_prev_reg && !read_active)
			rd_ptr_next = 1'h1;
	end

	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			rd_ptr_reg <= 1'h0;
			rd_prev_reg <= 1'h0;
		end
		else
		begin
			rd_ptr_reg <= rd_ptr_next;
			rd_prev_reg <= rd_prev_next;
		end
	end

	dacrp_result_mem #(
		.WIDTH(DATA_W)
	) u_mem (
		.clk_in(clk_in),
		.rstn_in(rstn_in),
		.wr_en_in(conv_end),
		.wr_data1_in(code_result(hold1_reg)),
		.wr_data2_in(code_result(hold2_reg)),
		.rd_sel_in(rd_ptr_reg),
		.rd_data_out(mem_data)
	);

	// data lines float unless both strobes are low
	assign result_bus_oe_out = read_active;
	assign result_bus_out = read_active ? mem_data : '0;

	////////////////////////////////////////////////////////////////////////
	a_busy_rise: assert property (@(posedge clk_in) disable iff (!rstn_in)
		(start_edge && !busy_out) |=> busy_out)
		else $error("busy did not rise after start edge");
	a_busy_len: assert property (@(posedge clk_in) disable iff (!rstn_in)
		$rose(busy_out) && !sleep_reg |-> busy_out [*8] ##[1:643] !busy_out)
		else $error("busy interval wrong");
	a_busy_sleep: assert property (@(posedge clk_in) disable iff (!rstn_in)
		$fell(busy_out) && sleep_reg |-> busy_span_reg == DACRP_CNT_W'(DACRP_SLEEP_CONV_CYCLES))
		else $error("auto sleep conversion length wrong");
	a_hold_capture: assert property (@(posedge clk_in) disable iff (!rstn_in)
		(start_edge && !busy_out) |=>
		hold1_reg == ($past(pair_select_in) ? $past(chan_b_input1_in) : $past(chan_a_input1_in)) &&
		hold2_reg == ($past(pair_select_in) ? $past(chan_b_input2_in) : $past(chan_a_input2_in)))
		else $error("held samples not from the selected pair");
	a_oe_gate: assert property (@(posedge clk_in) disable iff (!rstn_in)
		result_bus_oe_out == (!chip_select_n_in && !read_n_in))
		else $error("bus enable without both strobes");
	a_float_zero: assert property (@(posedge clk_in) disable iff (!rstn_in)
		!result_bus_oe_out |-> result_bus_out == '0)
		else $error("data driven while floating");
	a_pair_sel: assert property (@(posedge clk_in) disable iff (!rstn_in)
		(start_edge && !busy_out) |=> sel_reg == $past(pair_select_in))
		else $error("pair select not captured");
	a_seq_reset: assert property (@(posedge clk_in) disable iff (!rstn_in)
		(start_edge && !busy_out) |=> rd_ptr_reg == 1'h0)
		else $error("read sequence not reset");
	a_second_read: assert property (@(posedge clk_in) disable iff (!rstn_in)
		(rd_prev_reg && !read_active && !start_edge) |=> rd_ptr_reg)
		else $error("read pointer did not advance");
	c_conv_a: cover property (@(posedge clk_in) disable iff (!rstn_in) start_edge && !pair_select_in);
	c_conv_b: cover property (@(posedge clk_in) disable iff (!rstn_in) start_edge && pair_select_in);
	c_two_reads: cover property (@(posedge clk_in) disable iff (!rstn_in)
		rd_ptr_reg && read_active);
	c_done: cover property (@(posedge clk_in) disable iff (!rstn_in) conv_end);
endmodule : dacrp_top
`default_nettype wire

// ===== tb/dacrp_host.sv
`timescale 1ns/1ns
`default_nettype none
// host side of the parallel port; strobes change only at falling clock edges
module dacrp_host (
	// clock
	input wire logic clk_in,
	// host strobes
	output logic convert_start_n_out,
	output logic pair_select_out,
	output logic chip_select_n_out,
	output logic read_n_out
);
	initial
	begin
		convert_start_n_out = 1'h1;
		pair_select_out = 1'h0;
		chip_select_n_out = 1'h1;
		read_n_out = 1'h1;
	end
	////////////////////////////////////////////////////////////////
	// acquisition wait first, then select settles a cycle before the start edge
	task start(input logic sel);
		repeat (70) @(negedge clk_in);
		pair_select_out = sel;
		@(negedge clk_in);
		convert_start_n_out = 1'h0;
	endtask : start
	task release_start();
		convert_start_n_out = 1'h1;
	endtask : release_start
	// caller keeps reads out of the conversion window
	task bus(input logic cs_n, input logic rd_n);
		chip_select_n_out = cs_n;
		read_n_out = rd_n;
	endtask : bus
endmodule : dacrp_host
`default_nettype wire

// ===== tb/testbench.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin failures++; \
	$display("unexpected at %0t: got %h want %h", $time, a, b); end end
module testbench;
	import dacrp_pkg::*;
	localparam logic [13:0] A1 = 14'h0123;
	localparam logic [13:0] A2 = 14'h3abc;
	localparam logic [13:0] B1 = 14'h2001;
	localparam logic [13:0] B2 = 14'h1ffe;
	logic clk_in = 1'h0;
	logic rstn_in = 1'h0;
	logic auto_sleep_in = 1'h0;
	logic convert_start_n, pair_select, chip_select_n, read_n;
	logic busy_out, result_bus_oe_out, hold_out;
	logic [13:0] result_bus_out;
	logic [13:0] result_bus_bin;
	int failures = 0;
	int check_count = 0;
	always #4 clk_in = ~clk_in;
	////////////////////////////////////////////////////////////////
	dacrp_host host (.clk_in(clk_in), .convert_start_n_out(convert_start_n), .pair_select_out(pair_select),
		.chip_select_n_out(chip_select_n), .read_n_out(read_n));
	dacrp_top u_dut (.clk_in(clk_in), .rstn_in(rstn_in), .convert_start_n_in(convert_start_n),
		.pair_select_in(pair_select), .auto_sleep_in(auto_sleep_in), .busy_out(busy_out),
		.chan_a_input1_in(A1), .chan_a_input2_in(A2), .chan_b_input1_in(B1), .chan_b_input2_in(B2),
		.chip_select_n_in(chip_select_n), .read_n_in(read_n), .result_bus_out(result_bus_out),
		.result_bus_oe_out(result_bus_oe_out), .hold_out(hold_out));
	// unipolar coding variant on the same strobes
	dacrp_top #(.CODING(DACRP_CODE_BINARY)) u_dut_bin (.clk_in(clk_in), .rstn_in(rstn_in),
		.convert_start_n_in(convert_start_n), .pair_select_in(pair_select),
		.auto_sleep_in(auto_sleep_in), .busy_out(),
		.chan_a_input1_in(A1), .chan_a_input2_in(A2), .chan_b_input1_in(B1), .chan_b_input2_in(B2),
		.chip_select_n_in(chip_select_n), .read_n_in(read_n), .result_bus_out(result_bus_bin),
		.result_bus_oe_out(), .hold_out());
	////////////////////////////////////////////////////////////////
	task finish_test();
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : finish_test
	// busy is counted on falling edges, so the count equals the busy-high span
	task automatic conv(input logic sel, input logic slp, input int len);
		int n;
		@(negedge clk_in);
		auto_sleep_in = slp;
		host.start(sel);
		for (n = 0; n < 2000; n++)
		begin
			@(negedge clk_in);
			if (n == 0)
				`CHK(hold_out, 1'h1)
			if (n == 5)
				host.release_start();
			if (busy_out !== 1'h1)
				break;
		end
		`CHK(n, len)
	endtask : conv
	// strobes held two cycles since read data lag the pointer by one
	task automatic rd(input logic [13:0] e);
		@(negedge clk_in);
		host.bus(1'h0, 1'h0);
		repeat (2) @(negedge clk_in);
		`CHK(result_bus_oe_out, 1'h1)
		`CHK(result_bus_out, e ^ 14'h2000)
		`CHK(result_bus_bin, e)
		host.bus(1'h1, 1'h1);
		#1 `CHK(result_bus_oe_out, 1'h0)
	endtask : rd
	task automatic half_strobe(input logic cs_n, input logic rd_n);
		@(negedge clk_in);
		host.bus(cs_n, rd_n);
		@(negedge clk_in);
		`CHK(result_bus_oe_out, 1'h0)
		`CHK(result_bus_out, 14'h0)
		host.bus(1'h1, 1'h1);
	endtask : half_strobe
	////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (10) @(negedge clk_in);
		rstn_in = 1'h1;
		`CHK(busy_out, 1'h0)
		conv(1'h0, 1'h0, DACRP_CONV_CYCLES);
		rd(A1);
		rd(A2);
		half_strobe(1'h1, 1'h0);
		half_strobe(1'h0, 1'h1);
		conv(1'h1, 1'h1, DACRP_SLEEP_CONV_CYCLES);
		rd(B1);
		conv(1'h0, 1'h0, DACRP_CONV_CYCLES);
		rd(A1);
		rd(A2);
		finish_test();
	end
	// whole run is about 3000 cycles
	initial
	begin
		repeat (20000) @(posedge clk_in);
		failures++;
		finish_test();
	end
endmodule : testbench
`default_nettype wire
